// *** afr_pkg.sv ***
/*
  Shared constants and types of the converter's serial readout block:
  word sizes, command and register layout, status bits and timing.
  Assumes a 100 MHz system clock and a master clock well below it.
*/
package afr_pkg;

  // ****************************************
  // geometry
  // ****************************************
  localparam int AFR_CHANNELS = 2;
  localparam int SAMPLE_W = 24;
  localparam int WORD_W = 32;
  localparam int AFR_OSR_DEFAULT = 1024;
  localparam int BUF_DEPTH = 2;

  // ****************************************
  // word sizes
  // ****************************************
  localparam int WS_W = 2;
  localparam logic [1:0] WS_16 = 2'h0;
  localparam logic [1:0] WS_24 = 2'h1;
  localparam logic [1:0] WS_32_ZERO = 2'h2;
  localparam logic [1:0] WS_32_SIGN = 2'h3;
  localparam logic [1:0] WS_RESET = WS_24;
  localparam logic [5:0] LEN_16 = 6'h10;
  localparam logic [5:0] LEN_24 = 6'h18;
  localparam logic [5:0] LEN_32 = 6'h20;

  // ****************************************
  // command word and registers
  // ****************************************
  localparam logic [2:0] CMD_WRITE_OP = 3'h3;
  localparam int CMD_OP_LSB = 13;
  localparam int CMD_ADDR_LSB = 7;
  localparam int CMD_ADDR_W = 6;
  localparam logic [5:0] REG_MODE = 6'h02;
  localparam logic [5:0] REG_CLOCK = 6'h03;
  localparam logic [5:0] REG_THRESH_LO = 6'h10;
  localparam int MODE_RSTCLR_BIT = 10;
  localparam int MODE_WS_LSB = 8;
  localparam int MODE_PULSE_BIT = 0;
  localparam int CLOCK_EN_LSB = 8;
  localparam logic [7:0] THRESH_LO_RESET = 8'h00;
  // 0x09 in the low threshold byte gives a 622 mHz dc-removal corner
  localparam logic [7:0] DCR_CORNER_622MHZ = 8'h09;

  // ****************************************
  // status word
  // ****************************************
  localparam int STAT_RESYNC_BIT = 14;
  localparam int STAT_RESET_BIT = 10;
  localparam int STAT_WS_LSB = 8;
  localparam logic [2:0] WRITE_WORDS = 3'h2;
  localparam logic [2:0] WORD_IDX_MAX = 3'h7;

  // ****************************************
  // synchroniser lanes
  // ****************************************
  localparam int PIN_N = 5;
  localparam int PIN_CS = 4;
  localparam int PIN_SCLK = 3;
  localparam int PIN_SDI = 2;
  localparam int PIN_MCLK = 1;
  localparam int PIN_SYNC = 0;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int READY_PULSE_NS = 40;
  localparam logic [3:0] READY_PULSE_CYC =
    4'((READY_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef struct packed {
    logic [AFR_CHANNELS-1:0][SAMPLE_W-1:0] ch;
  } afr_sample_t;

endpackage : afr_pkg

// *** afr_pair_buffer.sv ***
/*
  Small FIFO holding conversion sample sets between the converter and
  the serial readout. Assumes one clock; flush empties it before the
  same cycle's write lands.
*/
`timescale 1ns/1ps
module afr_pair_buffer #(
  parameter int W = 48,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  input wire logic i_flush,
  // drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] count;

  wire do_pop = o_out_valid & i_out_ready & ~i_flush;
  wire do_push = i_in_valid & (o_in_ready | i_flush);
  wire [PW-1:0] wr_at = i_flush ? '0 : wr_ptr;
  wire [PW-1:0] wr_inc = (wr_at == PW'(DEPTH - 1)) ? '0 : wr_at + 1'b1;
  wire [PW-1:0] rd_inc = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
  wire [CW-1:0] base = i_flush ? '0 : count;
  wire [CW-1:0] next_count = base + CW'(do_push) - CW'(do_pop);

  assign o_in_ready = (count != CW'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data = mem[rd_ptr];

  always_ff @(posedge i_clk) begin
    if (do_push) begin
      mem[wr_at] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= do_push ? wr_inc : wr_at;
      rd_ptr <= i_flush ? '0 : (do_pop ? rd_inc : rd_ptr);
      count <= next_count;
    end
  end

endmodule : afr_pair_buffer

// *** afr_frame_readout.sv ***
/*
  Serial readout and configuration end of a two-channel converter:
  frame shifter (clock idle low, second-edge sampling), register writes,
  sample pacing from the master clock, ready output and resync check.
  Assumes the host drives chip select, serial clock and master clock;
  all pins are asynchronous to i_clk and at most a quarter of its rate.
*/
// Notes on behaviour
// - unread results overflow the two-deep store; ready fires every second period.
// - misaligned sync edge sets resync fault flag, again after any clear.
// - sync input only checks and realigns period timing, never starts conversions.
// - data consumed only after full frame; partial frame repeats same data.
// - ready output asserts when a new sample set lands in an empty store or flushes a full one.
// - word size is 24 bits after reset until changed.
// - word size 16, 24 or 32; 16-bit values sit left-justified.
// - register write is opcode-plus-address word then data word.
// - with all channels off, shortened frames still carry writes.
// - mode write clears reset flag on request and picks pulse ready.
// - 32-bit word options zero-pad or sign-extend the 24-bit result.
// - low threshold byte 0x09 sets dc-removal corner to 622 mHz.
// - frame is status, one word per channel, then optional all-zero crc slot word.
// - clock idles low, data sampled on second edge.
// - master clock halves to modulator clock; rate is that over oversampling.
// - data output released whenever chip select is high.
`timescale 1ns/1ps
module afr_frame_readout import afr_pkg::*; #(
  parameter int OSR = AFR_OSR_DEFAULT
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // serial link
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_sdi,
  output logic o_sdo,
  output logic o_sdo_oe,
  // pacing and ready
  input wire logic i_master_clock_in,
  input wire logic i_sync_n,
  output logic o_sample_ready_n,
  // converter side
  input wire afr_sample_t i_conv,
  input wire logic i_crc_en,
  // configuration and status
  output logic [AFR_CHANNELS-1:0] o_ch_enable,
  output logic [7:0] o_dc_removal_filter,
  output logic o_resync_fault_flag,
  output logic o_reset_flag
);
  localparam int OSR_W = (OSR > 1) ? $clog2(OSR) : 1;
  localparam int SW = $bits(afr_sample_t);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [PIN_N-1:0] pin_meta;
  logic [PIN_N-1:0] pin_sync;
  logic [PIN_N-1:0] pin_prev;
  wire [PIN_N-1:0] pins = {i_cs_n, i_sclk, i_sdi, i_master_clock_in, i_sync_n};

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      pin_meta <= '1;
      pin_sync <= '1;
      pin_prev <= '1;
    end else begin
      pin_meta <= pins;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  wire cs_n = pin_sync[PIN_CS];
  wire cs_fall = pin_prev[PIN_CS] & ~cs_n;
  wire cs_rise = ~pin_prev[PIN_CS] & cs_n;
  wire sclk_rise = ~pin_prev[PIN_SCLK] & pin_sync[PIN_SCLK] & ~cs_n;
  wire sclk_fall = pin_prev[PIN_SCLK] & ~pin_sync[PIN_SCLK] & ~cs_n;
  wire sdi = pin_sync[PIN_SDI];
  wire mclk_rise = ~pin_prev[PIN_MCLK] & pin_sync[PIN_MCLK];
  wire sync_fall = pin_prev[PIN_SYNC] & ~pin_sync[PIN_SYNC];

  // ****************************************
  // sample pacing and resync check
  // ****************************************
  logic mod_div;
  logic [OSR_W-1:0] mod_cnt;
  logic resync_flag;
  logic consume;
  wire mod_tick = mclk_rise & mod_div;
  wire period_tick = mod_tick & (mod_cnt == OSR_W'(OSR - 1));
  // a sync edge off the period boundary realigns timing and sets the resync flag
  wire misalign = sync_fall & ((mod_cnt != '0) | mod_div);
  wire next_resync = misalign | (resync_flag & ~consume);

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      mod_div <= 1'b0;
      mod_cnt <= '0;
      resync_flag <= 1'b0;
    end else begin
      resync_flag <= next_resync;
      if (sync_fall) begin
        mod_div <= 1'b0;
        mod_cnt <= '0;
      end else begin
        if (mclk_rise) begin
          mod_div <= ~mod_div;
        end
        if (mod_tick) begin
          mod_cnt <= period_tick ? '0 : mod_cnt + 1'b1;
        end
      end
    end
  end

  // ****************************************
  // output data store
  // ****************************************
  logic buf_in_ready;
  logic buf_out_valid;
  logic [SW-1:0] buf_out_data;
  // a tick into a full store drops both old sets, so one ready per two periods
  wire buf_flush = period_tick & ~buf_in_ready;
  wire new_set = period_tick & (~buf_out_valid | ~buf_in_ready);

  afr_pair_buffer #(
    .W(SW),
    .DEPTH(BUF_DEPTH)
  ) u_store (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_in_valid(period_tick),
    .o_in_ready(buf_in_ready),
    .i_in_data(i_conv),
    .i_flush(buf_flush),
    .o_out_valid(buf_out_valid),
    .i_out_ready(consume),
    .o_out_data(buf_out_data)
  );

  // ****************************************
  // configuration registers
  // ****************************************
  logic [WS_W-1:0] word_size;
  logic ready_pulse;
  logic reset_flag;
  logic [AFR_CHANNELS-1:0] ch_enable;
  logic [7:0] thresh_lo;
  logic [15:0] cmd_word;
  logic [15:0] data_word;
  logic [2:0] word_idx;
  logic [2:0] frame_words;

  wire [5:0] cur_len = (word_size == WS_16) ? LEN_16 :
                       (word_size == WS_24) ? LEN_24 : LEN_32;
  wire frame_full = (word_idx >= frame_words);
  wire all_off = ~|ch_enable;
  wire cmd_is_write = (cmd_word[CMD_OP_LSB +: 3] == CMD_WRITE_OP);
  wire [CMD_ADDR_W-1:0] cmd_addr = cmd_word[CMD_ADDR_LSB +: CMD_ADDR_W];
  wire apply = cs_rise & (frame_full | all_off) & (word_idx >= WRITE_WORDS)
               & cmd_is_write;
  wire wr_mode = apply & (cmd_addr == REG_MODE);
  wire wr_clock = apply & (cmd_addr == REG_CLOCK);
  wire wr_thresh = apply & (cmd_addr == REG_THRESH_LO);
  assign consume = cs_rise & frame_full;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      word_size <= WS_RESET;
      ready_pulse <= 1'b0;
      reset_flag <= 1'b1;
      ch_enable <= '1;
      thresh_lo <= THRESH_LO_RESET;
    end else begin
      if (wr_mode) begin
        word_size <= data_word[MODE_WS_LSB +: WS_W];
        ready_pulse <= data_word[MODE_PULSE_BIT];
      end
      if (wr_mode & data_word[MODE_RSTCLR_BIT]) begin
        reset_flag <= 1'b0;
      end
      if (wr_clock) begin
        ch_enable <= data_word[CLOCK_EN_LSB +: AFR_CHANNELS];
      end
      if (wr_thresh) begin
        thresh_lo <= data_word[7:0];
      end
    end
  end

  // ****************************************
  // ready output
  // ****************************************
  logic ready_n;
  logic [3:0] pulse_cnt;
  wire ready_release = ready_pulse ? (pulse_cnt == 4'h1) : cs_fall;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      ready_n <= 1'b1;
      pulse_cnt <= 4'h0;
    end else if (new_set) begin
      ready_n <= 1'b0;
      pulse_cnt <= READY_PULSE_CYC;
    end else begin
      ready_n <= ready_n | ready_release;
      pulse_cnt <= (pulse_cnt != 4'h0) ? pulse_cnt - 4'h1 : 4'h0;
    end
  end

  // ****************************************
  // frame shifter
  // ****************************************
  logic [5:0] frame_len;
  logic [WS_W-1:0] frame_ws;
  logic [5:0] bit_cnt;
  logic [WORD_W-1:0] tx_sh;
  logic [WORD_W-1:0] rx_sh;
  afr_sample_t frame_sample;

  wire [15:0] status16 = (16'(resync_flag) << STAT_RESYNC_BIT)
                       | (16'(reset_flag) << STAT_RESET_BIT)
                       | (16'(word_size) << STAT_WS_LSB)
                       | 16'({AFR_CHANNELS{buf_out_valid}});
  wire [WORD_W-1:0] rx_next = {rx_sh[WORD_W-2:0], sdi};
  wire [WORD_W-1:0] rx_left = rx_next << (LEN_32 - frame_len);
  wire word_done = sclk_fall & (bit_cnt == frame_len - 6'h1);
  wire [2:0] idx_next = (word_idx == WORD_IDX_MAX) ? word_idx : word_idx + 3'h1;

  function automatic logic [WORD_W-1:0] slot_word(input logic [2:0] idx,
      input logic [WS_W-1:0] ws, input afr_sample_t smp);
    logic [SAMPLE_W-1:0] s;
    s = '0;
    slot_word = '0;
    if (idx != 3'h0 && idx <= 3'(AFR_CHANNELS)) begin
      s = smp.ch[idx - 3'h1];
      unique case (ws)
        WS_16: slot_word = {s[SAMPLE_W-1 -: 16], 16'h0000};
        WS_24: slot_word = {s, 8'h00};
        WS_32_ZERO: slot_word = {s, 8'h00};
        WS_32_SIGN: slot_word = {{8{s[SAMPLE_W-1]}}, s};
      endcase
    end
  endfunction : slot_word

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      frame_len <= LEN_24;
      frame_ws <= WS_RESET;
      frame_words <= 3'(AFR_CHANNELS + 1);
      word_idx <= '0;
      bit_cnt <= '0;
      tx_sh <= '0;
      rx_sh <= '0;
      cmd_word <= '0;
      data_word <= '0;
      frame_sample <= '0;
      o_sdo <= 1'b0;
      o_sdo_oe <= 1'b0;
    end else begin
      o_sdo_oe <= ~cs_n;
      if (cs_fall) begin
        // size and data are frozen for the frame; changes land at the next
        frame_len <= cur_len;
        frame_ws <= word_size;
        frame_words <= 3'(AFR_CHANNELS + 1) + 3'(i_crc_en);
        word_idx <= '0;
        bit_cnt <= '0;
        // an empty store sends zero slots rather than unwritten entries
        frame_sample <= buf_out_valid ? buf_out_data : '0;
        tx_sh <= {status16, 16'h0000};
      end else if (sclk_rise) begin
        o_sdo <= tx_sh[WORD_W-1];
        tx_sh <= tx_sh << 1;
      end else if (sclk_fall) begin
        rx_sh <= rx_next;
        bit_cnt <= word_done ? 6'h0 : bit_cnt + 6'h1;
        if (word_done) begin
          word_idx <= idx_next;
          tx_sh <= slot_word(idx_next, frame_ws, frame_sample);
          if (word_idx == 3'h0) begin
            cmd_word <= rx_left[WORD_W-1 -: 16];
          end
          if (word_idx == 3'h1) begin
            data_word <= rx_left[WORD_W-1 -: 16];
          end
        end
      end
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_sample_ready_n <= 1'b1;
      o_ch_enable <= '1;
      o_dc_removal_filter <= THRESH_LO_RESET;
      o_resync_fault_flag <= 1'b0;
      o_reset_flag <= 1'b1;
    end else begin
      o_sample_ready_n <= ready_n;
      o_ch_enable <= ch_enable;
      o_dc_removal_filter <= thresh_lo;
      o_resync_fault_flag <= resync_flag;
      o_reset_flag <= reset_flag;
    end
  end

endmodule : afr_frame_readout

// *** afr_frame_readout_sva.sv ***
/*
  Concurrent checks on the pins and status outputs of the readout block.
  Assumes the host keeps serial clock phases of at least six cycles.
*/
`timescale 1ns/1ps
module afr_frame_readout_sva import afr_pkg::*; #(
  parameter int OSR = AFR_OSR_DEFAULT
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // serial link and ready
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic o_sdo,
  input wire logic o_sdo_oe,
  input wire logic o_sample_ready_n,
  // configuration and status
  input wire logic [AFR_CHANNELS-1:0] o_ch_enable,
  input wire logic [7:0] o_dc_removal_filter,
  input wire logic o_resync_fault_flag,
  input wire logic o_reset_flag
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  oe_idle_a: assert property (i_cs_n [*6] |-> !o_sdo_oe)
    else $error("data output driven while deselected");
  oe_drive_a: assert property ((!i_cs_n) [*6] |-> o_sdo_oe)
    else $error("data output not driven while selected");
  reset_state_a: assert property ($rose(i_rstn) |-> o_reset_flag && o_sample_ready_n
    && !o_resync_fault_flag && !o_sdo_oe && o_ch_enable == 2'h3)
    else $error("bad state after reset");
  ready_low_a: assert property ($fell(o_sample_ready_n) |=> !o_sample_ready_n [*3])
    else $error("ready low too briefly");
  flag_clear_a: assert property ($fell(o_reset_flag) |-> i_cs_n && $past(i_cs_n, 3))
    else $error("reset flag cleared inside a frame");
  filter_write_a: assert property (!$stable(o_dc_removal_filter) |-> $past(i_cs_n, 3))
    else $error("filter byte changed inside a frame");
  chen_write_a: assert property (!$stable(o_ch_enable) |-> i_cs_n && $past(i_cs_n, 3))
    else $error("channel enables changed inside a frame");
  sdo_shift_a: assert property (o_sdo_oe && $past(o_sdo_oe) && !$stable(o_sdo)
    |-> $past(i_sclk, 3))
    else $error("data output changed away from a rising clock");

  cover property ($fell(o_sample_ready_n));
  cover property ($rose(o_resync_fault_flag));
  cover property ($fell(o_reset_flag));
endmodule : afr_frame_readout_sva

bind afr_frame_readout afr_frame_readout_sva #(.OSR(OSR)) i_sva (.i_clk(i_clk),
  .i_rstn(i_rstn), .i_cs_n(i_cs_n), .i_sclk(i_sclk), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe),
  .o_sample_ready_n(o_sample_ready_n), .o_ch_enable(o_ch_enable),
  .o_dc_removal_filter(o_dc_removal_filter), .o_resync_fault_flag(o_resync_fault_flag),
  .o_reset_flag(o_reset_flag));

// *** afr_host_model.sv ***
/*
  Behavioural host controller: free master clock and serial frames.
  Assumes i_clk at 100 MHz; every call starts just after a clock edge.
*/
`timescale 1ns/1ps
module afr_host_model (
  // clock
  input wire logic i_clk,
  // serial link
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_sdi,
  input wire logic i_sdo,
  input wire logic i_sdo_oe,
  // master clock
  output logic o_master_clock_in
);
  logic [31:0] rx [0:3];
  logic [2:0] mdiv = 3'h0;
  logic last_sdo = 1'b0;
  logic sdo_line;

  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_sdi = 1'b0;
  end
  always @(posedge i_clk) begin
    mdiv <= mdiv + 3'h1;
    if (i_sdo_oe) begin
      last_sdo <= i_sdo;
    end
  end
  assign o_master_clock_in = mdiv[2];
  // a released line shows no stale bit
  assign sdo_line = i_sdo_oe ? i_sdo : ~last_sdo;

  task automatic xfer(input int nw, input int len, input logic [31:0] w0,
                      input logic [31:0] w1);
    logic [31:0] tx;
    o_cs_n <= 1'b0;
    repeat (6) @(posedge i_clk);
    for (int w = 0; w < nw; w++) begin
      tx = (w == 0) ? w0 : ((w == 1) ? w1 : 32'h0);
      rx[w] = 32'h0;
      for (int b = len - 1; b >= 0; b--) begin
        o_sclk <= 1'b1;
        o_sdi <= tx[b];
        repeat (6) @(posedge i_clk);
        rx[w][b] = sdo_line;
        o_sclk <= 1'b0;
        repeat (6) @(posedge i_clk);
      end
    end
    o_cs_n <= 1'b1;
    o_sdi <= ~o_sdi;
    repeat (8) @(posedge i_clk);
  endtask : xfer
endmodule : afr_host_model

// *** afr_tb.sv ***
/*
  Self-checking bench of the readout block against a queue model.
  Assumes the host model for all link traffic and a shortened OSR.
*/
`timescale 1ns/1ps
module tb;
  import afr_pkg::*;
  localparam int OSR_SIM = 128;
  localparam int PERIOD = 2 * OSR_SIM * 8;
  logic i_clk = 1'b0;
  logic rstn = 1'b0;
  logic sync_n = 1'b1;
  logic crc_en = 1'b0;
  afr_sample_t conv = '0;
  logic cs_n, sclk, sdi, mclk, sdo, sdo_oe, ready_n, rs_flag, rst_flag;
  logic [AFR_CHANNELS-1:0] ch_en;
  logic [7:0] filt;
  logic [31:0] lfsr = 32'hc9580a62;
  afr_sample_t exp_q[$];
  logic [1:0] ws_now = WS_RESET;
  logic rfe = 1'b1;
  longint t_fall;
  int failures = 0;
  int checks = 0;

  always #5 i_clk = ~i_clk;

  afr_frame_readout #(.OSR(OSR_SIM)) i_dut (.i_clk(i_clk), .i_rstn(rstn), .i_cs_n(cs_n),
    .i_sclk(sclk), .i_sdi(sdi), .o_sdo(sdo), .o_sdo_oe(sdo_oe), .i_master_clock_in(mclk),
    .i_sync_n(sync_n), .o_sample_ready_n(ready_n), .i_conv(conv), .i_crc_en(crc_en),
    .o_ch_enable(ch_en), .o_dc_removal_filter(filt), .o_resync_fault_flag(rs_flag),
    .o_reset_flag(rst_flag));
  afr_host_model i_host (.i_clk(i_clk), .o_cs_n(cs_n), .o_sclk(sclk), .o_sdi(sdi),
    .i_sdo(sdo), .i_sdo_oe(sdo_oe), .o_master_clock_in(mclk));

  // ****************************************
  // model and helpers
  // ****************************************
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  function automatic int wlen(input logic [1:0] ws);
    return (ws == WS_16) ? 16 : ((ws == WS_24) ? 24 : 32);
  endfunction : wlen
  function automatic logic [31:0] just(input logic [15:0] v);
    return 32'(v) << (wlen(ws_now) - 16);
  endfunction : just
  function automatic logic [31:0] fmt(input logic [23:0] s);
    case (ws_now)
      WS_16: return 32'(s[23:8]);
      WS_24: return 32'(s);
      WS_32_ZERO: return {s, 8'h00};
      default: return {{8{s[23]}}, s};
    endcase
  endfunction : fmt

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic close_out;
    if (failures == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out
  task automatic do_reset;
    rstn <= 1'b0;
    repeat (8) @(posedge i_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge i_clk);
    ws_now = WS_RESET;
    rfe = 1'b1;
    check(32'(rst_flag), 32'h1);
    check(32'(ready_n), 32'h1);
  endtask : do_reset
  task automatic wr(input logic [5:0] a, input logic [15:0] d, input int nw);
    i_host.xfer(nw, wlen(ws_now), just({CMD_WRITE_OP, a, 7'h00}), just(d));
  endtask : wr
  // the store holds one set right after each fall, so a prompt read is exact
  task automatic wait_ready(input logic push);
    int n;
    n = 0;
    for (int ph = 1; ph >= 0; ph--) begin
      while (ready_n !== ph[0] && n < 3 * PERIOD) begin
        @(posedge i_clk);
        n++;
      end
    end
    if (n >= 3 * PERIOD) begin
      check(32'h0, 32'h1);
    end
    t_fall = $time;
    if (push) begin
      exp_q.push_back(conv);
      lfsr = lfsr_next(lfsr);
      conv.ch[0] <= lfsr[23:0];
      lfsr = lfsr_next(lfsr);
      conv.ch[1] <= lfsr[31:8];
    end
  endtask : wait_ready
  task automatic read_frame(input logic [31:0] w0, input logic [31:0] w1, input logic rs);
    afr_sample_t e;
    logic [31:0] st;
    i_host.xfer(3 + int'(crc_en), wlen(ws_now), w0, w1);
    e = exp_q.pop_front();
    st = (i_host.rx[0] >> (wlen(ws_now) - 16)) & 32'h4700;
    check(st, {17'h0, rs, 3'h0, rfe, ws_now, 8'h00});
    check(i_host.rx[1], fmt(e.ch[0]));
    check(i_host.rx[2], fmt(e.ch[1]));
    if (crc_en) begin
      check(i_host.rx[3], 32'h0);
    end
  endtask : read_frame

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    int n;
    longint t1;
    do_reset();
    // channels are on after reset, so only a full frame may carry this write
    wr(REG_CLOCK, 16'h0000, 3 + int'(crc_en));
    check(32'(ch_en), 32'h0);
    wr(REG_THRESH_LO, 16'(DCR_CORNER_622MHZ), 2);
    check(32'(filt), 32'h9);
    wr(REG_MODE, 16'h0500, 2);
    rfe = 1'b0;
    check(32'(rst_flag), 32'h0);
    wr(REG_CLOCK, 16'h0300, 2);
    check(32'(ch_en), 32'h3);
    wr(REG_THRESH_LO, 16'h0055, 2);
    check(32'(filt), 32'h9);
    wait_ready(1'b1);
    for (int k = 0; k < 4; k++) begin
      crc_en <= k[0];
      @(posedge i_clk);
      read_frame(just({CMD_WRITE_OP, REG_MODE, 7'h00}), just({6'h0, 2'(k), 8'h00}), 1'b0);
      ws_now = 2'(k);
      wait_ready(1'b1);
    end
    crc_en <= 1'b0;
    i_host.xfer(1, wlen(ws_now), 32'h0, 32'h0);
    read_frame(32'h0, 32'h0, 1'b0);
    for (int r = 0; r < 2; r++) begin
      sync_n <= 1'b0;
      repeat (4) @(posedge i_clk);
      sync_n <= 1'b1;
      repeat (8) @(posedge i_clk);
      check(32'(rs_flag), 32'h1);
      check(32'(ready_n), 32'h1);
      wait_ready(1'b1);
      read_frame(just({CMD_WRITE_OP, REG_MODE, 7'h00}), just({6'h0, ws_now, 7'h0, r[0]}), 1'b1);
      check(32'(rs_flag), 32'h0);
    end
    wait_ready(1'b0);
    t1 = t_fall;
    n = 0;
    while (ready_n === 1'b0 && n < 16) begin
      @(posedge i_clk);
      n++;
    end
    check(32'(n), 32'(READY_PULSE_CYC));
    wait_ready(1'b1);
    check(32'((t_fall - t1) / 10), 32'(2 * PERIOD));
    read_frame(32'h0, 32'h0, 1'b0);
    do_reset();
    wait_ready(1'b1);
    read_frame(32'h0, 32'h0, 1'b0);
    close_out();
  end

  initial begin
    repeat (40 * PERIOD) @(posedge i_clk);
    failures++;
    close_out();
  end
endmodule : tb
